/* File: src/cbp_pkg.sv */
package cbp_pkg;

	// Bus geometry
	localparam int unsigned ADDR_W = 10;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_OVW = 8'haa;
	localparam logic [7:0] IDX_SYS = 8'hab;
	localparam logic [7:0] IDX_PORT = 8'hae;
	localparam logic [7:0] IDX_TST = 8'hc0;
	localparam logic [7:0] IDX_DIR = 8'hc1;
	localparam logic [7:0] IDX_EDGE = 8'hc2;
	localparam logic [7:0] IDX_CMP = 8'hc3;
	localparam logic [7:0] IDX_CMD = 8'hc4;
	localparam logic [7:0] IDX_CFLG = 8'hc5;
	localparam logic [7:0] IDX_OFLG = 8'hc6;
	localparam logic [7:0] IDX_CNT = 8'hc7;
	localparam logic [7:0] IDX_CAP0 = 8'hc8;
	localparam logic [7:0] IDX_HLD0 = 8'hcc;
	localparam logic [7:0] IDX_PAC0 = 8'hd0;

	// Field positions
	localparam int unsigned SYS_LATCH_QUEUE_SELECT = 0;
	localparam int unsigned SYS_BUFFER_ENABLE = 1;
	localparam int unsigned SYS_ACCUMULATOR_SATURATE = 2;
	localparam int unsigned SYS_FLAG_SETTING_MODE = 3;
	localparam int unsigned SYS_SH_LO = 4;
	localparam int unsigned TST_BYP = 1;
	localparam int unsigned CMD_FLAT = 0;
	localparam int unsigned CMP_OM7 = 8;
	localparam int unsigned CMP_OL7 = 9;
	localparam int unsigned CMP_MSK7 = 10;

	// Reset values
	localparam logic [7:0] OVW_RST = 8'h00;
	localparam logic [7:0] SYS_RST = 8'h00;
	localparam logic [7:0] TST_RST = 8'h00;
	localparam logic [7:0] DIR_RST = 8'h00;
	localparam logic [7:0] PORT_RST = 8'h00;
	localparam logic [15:0] EDGE_RST = 16'h0000;
	localparam logic [10:0] CMP_RST = 11'h000;

	// Counter constants
	localparam logic [7:0] BYTE_MAX = 8'hff;
	localparam logic [15:0] WORD_MAX = 16'hffff;

endpackage

/* File: src/cbp_capture_ctrl.sv */
// Notes on behaviour
// - Capture empties when read or moved to holding; holding empties only when read.
// - Per-channel no-overwrite bit blocks event writes into full capture/holding.
// - System control accepts one write in normal mode, every write otherwise.
// - Share bit routes pin and edge detector of x to channel y.
// - Queue, flag mode, no-overwrite: first event fills capture only; next moves and flags.
// - Flag mode 0: flag per valid edge; 1 in queue: flag on holding latch.
// - Accumulator wraps FF to 00, or sticks at FF when saturate set.
// - Buffer enable 0 disables holding registers; 1 uses latch/queue select.
// - Force-latch write of one latches immediately when buffer and latch mode on.
// - Queue mode: capture timer; later capture shifts old value into holding first.
// - Latch mode: latch on modulus reaching zero or zero written to it.
// - Latch copies captures and accumulators to holding, then clears accumulators.
// - Test register readable always, writable only in special mode.
// - Bypass splits counter into two bytes both clocked every module clock.
// - In bypass, overflow flag sets when high byte rolls FF to 00.
// - Port read returns pin level for inputs, latch for outputs.
// - Port writes always update latch; pins driven only as general outputs.
// - Pin 7 feeds accumulator only with mode, level and mask bits all zero.
// - Enabled compare forces pin to output; direction bit kept but ignored.
// - Enabled capture never overrides the direction bit.
// - Direction 0 is input unless a timer overrides, 1 is always output.
`timescale 1ns/1ps
`default_nettype none

module cbp_capture_ctrl #(
	parameter logic [7:0] PRESCALE_DIV = 8'h01
) (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RSTN_I,
	// Avalon-MM slave
	input wire logic [cbp_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [31:0] AVS_WRITEDATA_I,
	input wire logic [3:0] AVS_BYTEENABLE_I,
	output logic [31:0] AVS_READDATA_O,
	output logic AVS_WAITREQUEST_O,
	// Chip mode levels
	input wire logic NORMAL_MODE_I,
	input wire logic SPECIAL_MODE_I,
	// Modulus counter and compare events
	input wire logic MOD_ZERO_I,
	input wire logic MOD_WRITE_ZERO_I,
	input wire logic CNT_RESET_I,
	input wire logic [7:0] OC_LEVEL_I,
	// Timer port pins
	input wire logic [7:0] PIN_I,
	output logic [7:0] PIN_O,
	output logic [7:0] PIN_OE_O,
	// Accumulator feed from pin 7
	output logic PAC7_IN_O
);

	typedef struct packed {
		// Bus side
		logic wt;
		logic [31:0] rdata;

		// Software registers
		logic [7:0] ovw;
		logic [7:0] sys;
		logic sys_wr;
		logic [7:0] tst;
		logic [7:0] dir;
		logic [7:0] port;
		logic [15:0] edge_cfg;
		logic [10:0] cmp;

		// Timer and flags
		logic [3:0] cflg;
		logic timer_overflow_flag;
		logic [15:0] cnt;
		logic [7:0] pre;

		// Capture channels
		logic [3:0][15:0] cap;
		logic [3:0][15:0] hold;
		logic [3:0][7:0] pac;
		logic [3:0][7:0] pach;
		logic [3:0] cap_full;
		logic [3:0] hold_full;

		// Pin path
		logic [7:0] s1;
		logic [7:0] s2;
		logic [7:0] s3;
		logic pac7;
		logic [7:0] pin_o;
		logic [7:0] oe;
	} cbp_state_t;

	cbp_state_t q;
	cbp_state_t d;
	logic [1:0] rst_sync_q;
	logic rst_n;

	// Byte lane 0 carries every 8-bit register
	function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		merge8 = be[0] ? wd[7:0] : old;
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

	// Saturating step holds at the top instead of wrapping
	function automatic logic [7:0] pac_inc(input logic [7:0] v, input logic sat);
		if (sat && v == cbp_pkg::BYTE_MAX) begin
			pac_inc = v;
		end else begin
			pac_inc = 8'(v + 8'h01);
		end
	endfunction

	// Reset release through two flops
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	always_comb begin
		logic [7:0] idx;
		logic req;
		logic acc_rd;
		logic acc_wr;
		logic [1:0] ch;
		logic [7:0] ev;
		logic [3:0] chev;
		logic buf_en;
		logic latch_queue_select;
		logic queue;
		logic flag_setting_mode;
		logic latch_evt;
		logic force_lat;
		logic [7:0] base;
		logic [7:0] rv;
		logic [1:0] ecfg;
		idx = AVS_ADDRESS_I[cbp_pkg::ADDR_W-1:2];
		req = AVS_READ_I | AVS_WRITE_I;
		acc_rd = AVS_READ_I & ~q.wt;
		acc_wr = AVS_WRITE_I & ~q.wt;
		ch = idx[1:0];
		ev = '0;
		chev = '0;
		base = '0;
		rv = '0;
		ecfg = '0;
		buf_en = 1'b0;
		latch_queue_select = 1'b0;
		flag_setting_mode = 1'b0;
		queue = 1'b0;
		latch_evt = 1'b0;
		force_lat = 1'b0;
		d = q;

		// One wait cycle per access; action at the edge where wait is low
		d.wt = !(req && q.wt);
		if (AVS_READ_I && q.wt) begin
			// Unmapped indices read as zero
			d.rdata = '0;
			for (int i = 0; i < 8; i++) begin
				rv[i] = q.oe[i] ? q.port[i] : q.s2[i];
			end
			case (idx)
				cbp_pkg::IDX_OVW: d.rdata = {24'h000000, q.ovw};
				cbp_pkg::IDX_SYS: d.rdata = {24'h000000, q.sys};
				cbp_pkg::IDX_PORT: d.rdata = {24'h000000, rv};
				cbp_pkg::IDX_TST: d.rdata = {24'h000000, q.tst};
				cbp_pkg::IDX_DIR: d.rdata = {24'h000000, q.dir};
				cbp_pkg::IDX_EDGE: d.rdata = {16'h0000, q.edge_cfg};
				cbp_pkg::IDX_CMP: d.rdata = {21'h000000, q.cmp};
				cbp_pkg::IDX_CFLG: d.rdata = {28'h0000000, q.cflg};
				cbp_pkg::IDX_OFLG: d.rdata = {31'h00000000, q.timer_overflow_flag};
				cbp_pkg::IDX_CNT: d.rdata = {16'h0000, q.cnt};
				default: begin
					if (idx[7:2] == cbp_pkg::IDX_CAP0[7:2]) begin
						d.rdata = {16'h0000, q.cap[ch]};
					end else if (idx[7:2] == cbp_pkg::IDX_HLD0[7:2]) begin
						d.rdata = {16'h0000, q.hold[ch]};
					end else if (idx[7:2] == cbp_pkg::IDX_PAC0[7:2]) begin
						d.rdata = {16'h0000, q.pach[ch], q.pac[ch]};
					end
				end
			endcase
		end

		// Reads that empty buffers, before events so a same-cycle event wins
		if (acc_rd && idx[7:2] == cbp_pkg::IDX_CAP0[7:2]) begin
			d.cap_full[ch] = 1'b0;
		end
		if (acc_rd && idx[7:2] == cbp_pkg::IDX_HLD0[7:2]) begin
			d.hold_full[ch] = 1'b0;
		end

		if (acc_wr) begin
			unique case (idx)
				cbp_pkg::IDX_OVW: d.ovw = merge8(q.ovw, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
				cbp_pkg::IDX_SYS: begin
					if (!NORMAL_MODE_I || !q.sys_wr) begin
						d.sys = merge8(q.sys, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
						d.sys_wr = 1'b1;
					end
				end
				cbp_pkg::IDX_PORT: begin
					d.port = merge8(q.port, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
				end
				cbp_pkg::IDX_TST: begin
					if (SPECIAL_MODE_I) begin
						d.tst = merge8(q.tst, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
					end
				end
				cbp_pkg::IDX_DIR: d.dir = merge8(q.dir, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
				cbp_pkg::IDX_EDGE: begin
					d.edge_cfg = merge16(q.edge_cfg, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
				end
				cbp_pkg::IDX_CMP: begin
					d.cmp = {AVS_BYTEENABLE_I[1] ? AVS_WRITEDATA_I[10:8] : q.cmp[10:8],
						AVS_BYTEENABLE_I[0] ? AVS_WRITEDATA_I[7:0] : q.cmp[7:0]};
				end
				cbp_pkg::IDX_CMD: begin
					force_lat = AVS_BYTEENABLE_I[0] & AVS_WRITEDATA_I[cbp_pkg::CMD_FLAT];
				end
				cbp_pkg::IDX_CFLG: begin
					// Write one to clear; an event in the same cycle still sets
					if (AVS_BYTEENABLE_I[0]) begin
						d.cflg = q.cflg & ~AVS_WRITEDATA_I[3:0];
					end
				end
				cbp_pkg::IDX_OFLG: begin
					if (AVS_BYTEENABLE_I[0] && AVS_WRITEDATA_I[0]) begin
						d.timer_overflow_flag = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		// Free-running counter; flag sets after the clear so set wins
		if (CNT_RESET_I) begin
			d.cnt = '0;
			d.pre = '0;
		end else if (q.tst[cbp_pkg::TST_BYP]) begin
			d.cnt[7:0] = 8'(q.cnt[7:0] + 8'h01);
			d.cnt[15:8] = 8'(q.cnt[15:8] + 8'h01);
			// Prescaler parked so normal counting restarts from a clean phase
			d.pre = '0;
			if (q.cnt[15:8] == cbp_pkg::BYTE_MAX) begin
				d.timer_overflow_flag = 1'b1;
			end
		end else if (q.pre >= 8'(PRESCALE_DIV - 8'h01)) begin
			d.pre = '0;
			d.cnt = 16'(q.cnt + 16'h0001);
			if (q.cnt == cbp_pkg::WORD_MAX) begin
				d.timer_overflow_flag = 1'b1;
			end
		end else begin
			d.pre = 8'(q.pre + 8'h01);
		end

		// Two-flop synchroniser, third flop only for edge history
		d.s1 = PIN_I;
		d.s2 = q.s1;
		d.s3 = q.s2;
		// Edges judged on settled samples only, never on the first flop
		for (int i = 0; i < 8; i++) begin
			ecfg = q.edge_cfg[2*i +: 2];
			ev[i] = (ecfg[0] & q.s2[i] & ~q.s3[i]) | (ecfg[1] & ~q.s2[i] & q.s3[i]);
		end
		// A shared channel follows the upper pin and ignores its own
		for (int y = 0; y < 4; y++) begin
			chev[y] = q.sys[cbp_pkg::SYS_SH_LO + y] ? ev[y + 4] : ev[y];
		end

		buf_en = q.sys[cbp_pkg::SYS_BUFFER_ENABLE];
		latch_queue_select = q.sys[cbp_pkg::SYS_LATCH_QUEUE_SELECT];
		flag_setting_mode = q.sys[cbp_pkg::SYS_FLAG_SETTING_MODE];
		queue = buf_en & ~latch_queue_select;
		latch_evt = buf_en & latch_queue_select & (MOD_ZERO_I | MOD_WRITE_ZERO_I | force_lat);

		for (int y = 0; y < 4; y++) begin
			// Latch mode: copy then clear accumulator
			if (latch_evt) begin
				if (!q.ovw[y] || !d.hold_full[y]) begin
					d.hold[y] = q.cap[y];
					d.pach[y] = q.pac[y];
					d.hold_full[y] = 1'b1;
					d.cap_full[y] = 1'b0;
				end
				base = '0;
			end else begin
				base = q.pac[y];
			end
			// Accumulators count in every mode; only a latch clears them
			d.pac[y] = chev[y] ? pac_inc(base, q.sys[cbp_pkg::SYS_ACCUMULATOR_SATURATE]) : base;

			if (chev[y]) begin
				if (queue) begin
					// Shift only when a value is pending, or always without protection
					if (d.cap_full[y] || !q.ovw[y]) begin
						if (!q.ovw[y] || !d.hold_full[y]) begin
							d.hold[y] = q.cap[y];
							d.hold_full[y] = 1'b1;
							d.cap[y] = q.cnt;
							d.cap_full[y] = 1'b1;
							if (flag_setting_mode) begin
								d.cflg[y] = 1'b1;
							end
						end
					end else begin
						d.cap[y] = q.cnt;
						d.cap_full[y] = 1'b1;
					end
					if (!flag_setting_mode) begin
						d.cflg[y] = 1'b1;
					end
				end else begin
					if (!q.ovw[y] || !d.cap_full[y]) begin
						d.cap[y] = q.cnt;
						d.cap_full[y] = 1'b1;
					end
					d.cflg[y] = 1'b1;
				end
			end
		end

		// Pin direction and drive from the settled control values
		for (int i = 0; i < 8; i++) begin
			d.oe[i] = d.cmp[i] | d.dir[i];
			d.pin_o[i] = d.cmp[i] ? OC_LEVEL_I[i] : d.port[i];
		end
		// Any channel-7 mode, level or mask bit blocks the feed; none of them drives the pin
		d.pac7 = ~(q.cmp[cbp_pkg::CMP_OM7] | q.cmp[cbp_pkg::CMP_OL7] |
			q.cmp[cbp_pkg::CMP_MSK7]) & q.s2[7];
	end

	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.wt <= 1'b1;
			q.ovw <= cbp_pkg::OVW_RST;
			q.sys <= cbp_pkg::SYS_RST;
			q.tst <= cbp_pkg::TST_RST;
			q.dir <= cbp_pkg::DIR_RST;
			q.port <= cbp_pkg::PORT_RST;
			q.edge_cfg <= cbp_pkg::EDGE_RST;
			q.cmp <= cbp_pkg::CMP_RST;
		end else begin
			q <= d;
		end
	end

	assign AVS_READDATA_O = q.rdata;
	assign AVS_WAITREQUEST_O = q.wt;
	assign PIN_O = q.pin_o;
	assign PIN_OE_O = q.oe;
	assign PAC7_IN_O = q.pac7;

endmodule

`default_nettype wire

/* File: tb/cbp_pin_source.sv */
`timescale 1ns/1ps
`default_nettype none
module cbp_pin_source (
	// Clock
	input wire logic clk_i,
	// Pin levels
	output logic [7:0] pins_o
);
	initial pins_o = 8'h00;
	task automatic drive(input logic [7:0] v);
		@(posedge clk_i);
		pins_o <= v;
	endtask
	// Never narrower than three clocks, so the synchroniser cannot miss it
	task automatic pulse(input int ch, input int w);
		int n;
		n = (w > 3) ? w : 3;
		@(posedge clk_i);
		pins_o[ch] <= 1'h1;
		repeat (n) @(posedge clk_i);
		pins_o[ch] <= 1'h0;
	endtask
endmodule
`default_nettype wire

/* File: tb/cbp_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module cbp_monitor (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RSTN_I,
	// Bus
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [31:0] AVS_READDATA_O,
	input wire logic AVS_WAITREQUEST_O,
	// Pins
	input wire logic [7:0] OC_LEVEL_I,
	input wire logic [7:0] PIN_I,
	input wire logic [7:0] PIN_O,
	input wire logic [7:0] PIN_OE_O,
	input wire logic PAC7_IN_O
);
	logic req;
	logic wdone;
	assign req = AVS_READ_I || AVS_WRITE_I;
	assign wdone = AVS_WRITE_I && !AVS_WAITREQUEST_O;
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RSTN_I);
	a_wait_answer: assert property (req && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
		else $error("request not answered");
	a_wait_pulse: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
		else $error("wait low too long");
	a_wait_idle: assert property (!req |=> AVS_WAITREQUEST_O)
		else $error("answer without request");
	a_rdata_hold: assert property ($changed(AVS_READDATA_O) |-> $past(AVS_READ_I))
		else $error("read data moved");
	a_dir_by_write: assert property ($changed(PIN_OE_O) |-> $past(wdone))
		else $error("pin direction moved without write");
	a_pin_cause: assert property ($changed(PIN_O) |->
		$past(wdone) || $past(OC_LEVEL_I) != $past(OC_LEVEL_I, 2))
		else $error("pin level moved without cause");
	a_pac7_source: assert property ($rose(PAC7_IN_O) |->
		$past(PIN_I[7], 2) || $past(PIN_I[7], 3))
		else $error("accumulator feed rose without pin");
	a_pac7_quiet: assert property ((!PIN_I[7]) [*4] |=> !PAC7_IN_O)
		else $error("accumulator feed high with pin low");
	cover property (wdone);
	cover property ($rose(PIN_OE_O[4]));
	cover property ($rose(PAC7_IN_O));
endmodule
bind cbp_capture_ctrl cbp_monitor i_mon (.CLK_I(CLK_I), .RSTN_I(RSTN_I),
	.AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_READDATA_O(AVS_READDATA_O),
	.AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .OC_LEVEL_I(OC_LEVEL_I), .PIN_I(PIN_I),
	.PIN_O(PIN_O), .PIN_OE_O(PIN_OE_O), .PAC7_IN_O(PAC7_IN_O));
`default_nettype wire

/* File: tb/capture_buffer_port_control_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module capture_buffer_port_control_bench;
	logic clk, rst_n, rd, wr, nrm, spc, mz, mwz, crst, waitreq, pac7;
	logic [9:0] adr;
	logic [31:0] wd, rdata, q, h;
	logic [7:0] ocl, src, pin_o, pin_oe, pin_w;
	int err_count, checked;
	// Module wins where it drives the pin
	assign pin_w = (pin_oe & pin_o) | (~pin_oe & src);
	cbp_pin_source i_src (.clk_i(clk), .pins_o(src));
	cbp_capture_ctrl i_dut (.CLK_I(clk), .RSTN_I(rst_n), .AVS_ADDRESS_I(adr),
		.AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(4'hf),
		.AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq), .NORMAL_MODE_I(nrm),
		.SPECIAL_MODE_I(spc), .MOD_ZERO_I(mz), .MOD_WRITE_ZERO_I(mwz), .CNT_RESET_I(crst),
		.OC_LEVEL_I(ocl), .PIN_I(pin_w), .PIN_O(pin_o), .PIN_OE_O(pin_oe), .PAC7_IN_O(pac7));
	task automatic tally_and_finish();
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] idx, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		adr <= {idx, 2'h0};
		wd <= d;
		wr <= w;
		rd <= !w;
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'h0 && n < 20);
		q = rdata;
		rd <= 1'h0;
		wr <= 1'h0;
		if (waitreq !== 1'h0) begin
			err_count++;
			tally_and_finish();
		end
	endtask
	task automatic rc(input string nm, input logic [7:0] idx, input logic [31:0] exp);
		acc(1'h0, idx, 32'h0);
		chk(nm, q, exp);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end
	initial begin
		rst_n = 1'h0;
		rd = 1'h0;
		wr = 1'h0;
		adr = 10'h0;
		wd = 32'h0;
		nrm = 1'h1;
		spc = 1'h0;
		mz = 1'h0;
		mwz = 1'h0;
		crst = 1'h0;
		ocl = 8'h10;
		err_count = 0;
		checked = 0;
		tick(12);
		rst_n <= 1'h1;
		tick(3);
		rc("ovw", cbp_pkg::IDX_OVW, 32'h0);
		rc("sys", cbp_pkg::IDX_SYS, 32'h0);
		rc("tst", cbp_pkg::IDX_TST, 32'h0);
		acc(1'h1, cbp_pkg::IDX_TST, 32'h2);
		rc("tst locked", cbp_pkg::IDX_TST, 32'h0);
		spc <= 1'h1;
		acc(1'h1, cbp_pkg::IDX_TST, 32'h2);
		rc("tst open", cbp_pkg::IDX_TST, 32'h2);
		acc(1'h0, cbp_pkg::IDX_CNT, 32'h0);
		h = q;
		acc(1'h0, cbp_pkg::IDX_CNT, 32'h0);
		chk("split", q, {16'h0, h[15:8] + 8'h3, h[7:0] + 8'h3});
		tick(300);
		rc("ovf", cbp_pkg::IDX_OFLG, 32'h1);
		acc(1'h1, cbp_pkg::IDX_TST, 32'h0);
		acc(1'h1, cbp_pkg::IDX_SYS, 32'h2);
		acc(1'h1, cbp_pkg::IDX_SYS, 32'h0);
		rc("sys once", cbp_pkg::IDX_SYS, 32'h2);
		nrm <= 1'h0;
		i_src.drive(8'hbc);
		acc(1'h1, cbp_pkg::IDX_DIR, 32'hf);
		acc(1'h1, cbp_pkg::IDX_PORT, 32'ha5);
		tick(4);
		rc("port", cbp_pkg::IDX_PORT, 32'hb5);
		chk("oe", pin_oe, 32'hf);
		acc(1'h1, cbp_pkg::IDX_CMP, 32'h10);
		tick(2);
		chk("oe cmp", pin_oe, 32'h1f);
		chk("pin cmp", pin_o[4:0], 32'h15);
		rc("dir kept", cbp_pkg::IDX_DIR, 32'hf);
		rc("port cmp", cbp_pkg::IDX_PORT, 32'ha5);
		acc(1'h1, cbp_pkg::IDX_CMP, 32'h0);
		tick(2);
		chk("oe off", pin_oe, 32'hf);
		crst <= 1'h1;
		tick(1);
		crst <= 1'h0;
		rc("cnt reset", cbp_pkg::IDX_CNT, 32'h1);
		acc(1'h1, cbp_pkg::IDX_DIR, 32'h0);
		i_src.drive(8'h0);
		acc(1'h1, cbp_pkg::IDX_EDGE, 32'h5);
		acc(1'h1, cbp_pkg::IDX_OVW, 32'h1);
		i_src.pulse(0, 4);
		tick(15);
		i_src.pulse(0, 4);
		tick(25);
		i_src.pulse(0, 4);
		tick(8);
		rc("flag", cbp_pkg::IDX_CFLG, 32'h1);
		acc(1'h0, cbp_pkg::IDX_HLD0, 32'h0);
		h = q;
		acc(1'h0, cbp_pkg::IDX_CAP0, 32'h0);
		chk("queue", {16'h0, q[15:0] - h[15:0]}, 32'h14);
		acc(1'h1, cbp_pkg::IDX_OVW, 32'h0);
		acc(1'h1, cbp_pkg::IDX_SYS, 32'h3);
		rc("sys again", cbp_pkg::IDX_SYS, 32'h3);
		for (int k = 0; k < 3; k++) begin
			i_src.pulse(0, 4);
			tick(15);
			i_src.pulse(1, 4);
			tick(8);
			if (k == 0) begin
				mz <= 1'h1;
				tick(1);
				mz <= 1'h0;
			end else if (k == 1) begin
				mwz <= 1'h1;
				tick(1);
				mwz <= 1'h0;
			end else begin
				acc(1'h1, cbp_pkg::IDX_CMD, 32'h1);
			end
			acc(1'h0, cbp_pkg::IDX_HLD0, 32'h0);
			h = q;
			acc(1'h0, cbp_pkg::IDX_HLD0 + 8'h1, 32'h0);
			chk("latch", {16'h0, q[15:0] - h[15:0]}, 32'h14);
			acc(1'h0, cbp_pkg::IDX_PAC0, 32'h0);
			chk("acc", {24'h0, q[7:0]}, 32'h0);
			chk("acc hold", {24'h0, q[15:8]}, (k == 0) ? 32'h4 : 32'h1);
		end
		acc(1'h1, cbp_pkg::IDX_SYS, 32'h10);
		acc(1'h1, cbp_pkg::IDX_EDGE, 32'h105);
		acc(1'h1, cbp_pkg::IDX_CFLG, 32'hf);
		i_src.pulse(4, 4);
		tick(8);
		rc("share", cbp_pkg::IDX_CFLG, 32'h1);
		acc(1'h1, cbp_pkg::IDX_SYS, 32'ha);
		acc(1'h1, cbp_pkg::IDX_OVW, 32'h1);
		acc(1'h0, cbp_pkg::IDX_CAP0, 32'h0);
		acc(1'h0, cbp_pkg::IDX_HLD0, 32'h0);
		acc(1'h1, cbp_pkg::IDX_CFLG, 32'hf);
		i_src.pulse(0, 4);
		tick(8);
		rc("flag_setting_mode first", cbp_pkg::IDX_CFLG, 32'h0);
		i_src.pulse(0, 4);
		tick(8);
		rc("flag_setting_mode second", cbp_pkg::IDX_CFLG, 32'h1);
		acc(1'h1, cbp_pkg::IDX_SYS, 32'h4);
		for (int k = 0; k < 260; k++) begin
			i_src.pulse(0, 3);
			tick(3);
		end
		tick(4);
		acc(1'h0, cbp_pkg::IDX_PAC0, 32'h0);
		chk("saturate", {24'h0, q[7:0]}, 32'hff);
		acc(1'h1, cbp_pkg::IDX_SYS, 32'h0);
		i_src.pulse(0, 3);
		tick(6);
		acc(1'h0, cbp_pkg::IDX_PAC0, 32'h0);
		chk("wrap", {24'h0, q[7:0]}, 32'h0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
